// [core/sd_drive_seq.sv]
`default_nettype none
module sd_drive_seq
    import sd_pkg::*;
#(
    parameter logic [SPIN_CW-1:0] SPINUP_CYC = SPINUP_CYC_DEF,
    parameter logic [SEEK_CW-1:0] SEEK_CYC = SEEK_CYC_DEF,
    parameter logic [HOLD_CW-1:0] HOLD_CYC = HOLD_CYC_DEF
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // drive pins
    input wire sd_pins_t pins_i,
    input wire logic [CYL_W-1:0] present_cyl_i,
    // actuator and panel
    output sd_act_t act_mode_o,
    output logic [CYL_W:0] pos_err_o,
    output logic power_hold_o,
    output logic door_lock_o,
    output logic unlock_lamp_o,
    output logic ready_o,
    output logic operational_o,
    output logic not_on_track_o,
    output logic rem_index_o,
    output logic rem_sector_o,
    output logic fix_index_o,
    output logic fix_sector_o
);
    // ==========================================================
    // input synchronisers
    sd_pins_t pins_m;
    sd_pins_t pins;

    // two flops on every pin
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pins_m <= '0;
            pins <= '0;
        end
        else
        begin
            pins_m <= pins_i;
            pins <= pins_m;
        end
    end

    // ==========================================================
    // sector decoders, one per disc
    logic [SECT_W-1:0] rem_sect;
    logic [SECT_W-1:0] fix_sect;

    sd_notch_dec u_rem
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .notch_i(pins.rem_notch),
        .index_o(rem_index_o),
        .sector_o(rem_sector_o),
        .sector_num_o(rem_sect)
    );

    sd_notch_dec u_fix
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .notch_i(pins.fix_notch),
        .index_o(fix_index_o),
        .sector_o(fix_sector_o),
        .sector_num_o(fix_sect)
    );

    // ==========================================================
    // register bus decode
    logic bus_req;
    logic wr_seek;
    logic wr_cmd;
    logic wr_drive;
    logic home_cmd;

    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_seek = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == REG_SEEK);
    assign wr_cmd = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == REG_CMD);
    assign wr_drive = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == REG_DRIVE);
    assign home_cmd = wr_cmd & wb_dat_i[CMD_HOME_BIT];

    // ==========================================================
    // sequencer state
    sd_state_t state;
    sd_state_t next_state;
    logic [SPIN_CW-1:0] spin_cnt;
    logic [SEEK_CW-1:0] seek_cnt;
    logic [HOLD_CW-1:0] hold_cnt;
    logic [CYL_W-1:0] cyl;
    logic [DRV_W-1:0] drive_num;
    logic unsafe;
    logic stop_req;
    logic on_track;
    logic seek_go;
    logic seek_late;
    logic spin_done;

    assign unsafe = pins.fault | ~pins.power_safe | ~pins.speed_ok;
    assign stop_req = ~pins.spin_req | pins.power_off_req;
    assign on_track = (present_cyl_i == cyl);
    assign seek_go = (wr_seek | home_cmd) & (state == ST_READY) & ~unsafe;
    assign seek_late = (state == ST_SEEK) && (seek_cnt >= SEEK_CYC);
    assign spin_done = (spin_cnt >= SPINUP_CYC);

    // next state
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (pins.spin_req && pins.cart_present && pins.dc_avail && !stop_req)
                    next_state = ST_SPINUP;
            end
            ST_SPINUP:
            begin
                if (stop_req)
                    next_state = ST_STOP;
                else if (pins.power_safe && pins.speed_ok)
                    next_state = ST_DELAY;
            end
            ST_DELAY:
            begin
                if (stop_req)
                    next_state = ST_STOP;
                else if (spin_done)
                    next_state = ST_LOAD;
            end
            ST_LOAD:
            begin
                // ready once at track 0 without fault
                if (stop_req)
                    next_state = ST_STOP;
                else if (on_track && !pins.fault)
                    next_state = ST_READY;
            end
            ST_READY:
            begin
                if (stop_req)
                    next_state = ST_STOP;
                else if (seek_go)
                    next_state = ST_SEEK;
            end
            ST_SEEK:
            begin
                if (stop_req)
                    next_state = ST_STOP;
                else if (on_track || seek_late)
                    next_state = ST_READY;
            end
            ST_STOP:
            begin
                // leave stop only once discs stopped
                if (pins.spin_stopped)
                    next_state = ST_IDLE;
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // start-up delay counts from spin start
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            spin_cnt <= '0;
        else if (state == ST_SPINUP || state == ST_DELAY)
        begin
            if (!spin_done)
                spin_cnt <= spin_cnt + 1'b1;
        end
        else
            spin_cnt <= '0;
    end

    // seek timeout restarts on each seek
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            seek_cnt <= '0;
        else if (seek_go)
            seek_cnt <= '0;
        else if (state == ST_SEEK && !seek_late)
            seek_cnt <= seek_cnt + 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cyl <= CYL_RST;
        else if (state == ST_IDLE || state == ST_SPINUP || state == ST_DELAY)
            cyl <= CYL_RST;
        else if (seek_go && wr_seek)
            cyl <= wb_dat_i[CYL_W-1:0];
        else if (seek_go)
            cyl <= CYL_RST;
    end

    // not-on-track flag, timeout wins over a clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            not_on_track_o <= 1'b0;
        else if (seek_late)
            not_on_track_o <= 1'b1;
        else if (seek_go || state == ST_IDLE)
            not_on_track_o <= 1'b0;
    end

    // power hold timer while spin still requested
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            hold_cnt <= '0;
            power_hold_o <= 1'b0;
        end
        else if (pins.power_off_req && pins.spin_req)
        begin
            if (hold_cnt < HOLD_CYC)
                hold_cnt <= hold_cnt + 1'b1;
            power_hold_o <= (hold_cnt < HOLD_CYC);
        end
        else
        begin
            hold_cnt <= '0;
            power_hold_o <= 1'b0;
        end
    end

    // ==========================================================
    // actuator drive
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            act_mode_o <= ACT_OFF;
            pos_err_o <= '0;
        end
        else
        begin
            pos_err_o <= {1'b0, present_cyl_i} - {1'b0, cyl};
            case (state)
                ST_SPINUP:
                    act_mode_o <= pins.power_safe ? ACT_REVERSE : ACT_OFF;
                ST_DELAY:
                    act_mode_o <= ACT_REVERSE;
                ST_LOAD, ST_READY, ST_SEEK:
                    act_mode_o <= ACT_SERVO;
                ST_STOP:
                    act_mode_o <= ACT_REVERSE;
                default:
                    act_mode_o <= ACT_OFF;
            endcase
        end
    end

    // ==========================================================
    // door and status outputs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            door_lock_o <= 1'b1;
            unlock_lamp_o <= 1'b0;
            ready_o <= 1'b0;
            operational_o <= 1'b0;
        end
        else
        begin
            // unlock only in idle with dc up, discs stopped and spin not requested
            door_lock_o <= !(state == ST_IDLE && pins.dc_avail && pins.spin_stopped
                             && !pins.spin_req);
            unlock_lamp_o <= state == ST_IDLE && pins.dc_avail && pins.spin_stopped
                             && !pins.spin_req;
            // ready after load, dropped when unsafe
            ready_o <= (state == ST_READY || state == ST_SEEK) && !unsafe;
            operational_o <= (state == ST_READY) && !unsafe;
        end
    end

    // drive number setting
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            drive_num <= DRV_RST;
        else if (wr_drive)
            drive_num <= wb_dat_i[DRV_W-1:0];
    end

    // ==========================================================
    // register read and acknowledge
    logic [31:0] rd_data;

    // read mux, unmapped reads zero
    always_comb
    begin
        rd_data = '0;
        case (wb_adr_i)
            REG_STATUS:
            begin
                rd_data[0] = ready_o;
                rd_data[1] = operational_o;
                rd_data[2] = not_on_track_o;
                rd_data[3] = (state == ST_SEEK);
                rd_data[4] = door_lock_o;
                rd_data[5] = pins.fault;
                rd_data[6] = power_hold_o;
                rd_data[14:8] = state;
            end
            REG_SEEK:
                rd_data[CYL_W-1:0] = cyl;
            REG_CMD:
                rd_data[CYL_W-1:0] = present_cyl_i;
            REG_DRIVE:
            begin
                rd_data[DRV_W-1:0] = drive_num;
                rd_data[11:8] = {drive_num, 1'b0};
                rd_data[19:16] = {drive_num, 1'b1};
            end
            REG_SECTOR:
            begin
                rd_data[SECT_W-1:0] = rem_sect;
                rd_data[SECT_W+7:8] = fix_sect;
            end
            default:
                rd_data = '0;
        endcase
    end

    // one wait state, ack dropped after one cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i)
                wb_dat_o <= rd_data;
        end
    end
endmodule : sd_drive_seq
`default_nettype wire

// [core/sd_notch_dec.sv]
`default_nettype none
// ==========================================================
// notch pair decoder: sector pulses, index and sector number
module sd_notch_dec
    import sd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic notch_i,
    output logic index_o,
    output logic sector_o,
    output logic [SECT_W-1:0] sector_num_o
);
    logic notch_d;
    logic phase;
    logic [NOTCH_CW-1:0] gap;
    logic [NOTCH_CW-1:0] last_gap;
    logic rise;
    logic early;
    logic seen;

    // an early notch comes in under half the usual spacing
    assign rise = notch_i & ~notch_d;
    assign early = rise && (gap < {1'b0, last_gap[NOTCH_CW-1:1]});

    // notch spacing measurement, saturating
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            notch_d <= 1'b0;
            gap <= '0;
            last_gap <= '0;
            seen <= 1'b0;
        end
        else
        begin
            notch_d <= notch_i;
            if (rise)
                seen <= 1'b1;
            if (rise)
                gap <= '0;
            else if (gap != '1)
                gap <= gap + 1'b1;
            // the run-in before the first notch is no spacing, so learn from the second
            if (rise && !early)
                last_gap <= seen ? gap : '0;
        end
    end

    // every other notch is a sector
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            index_o <= 1'b0;
            sector_o <= 1'b0;
            phase <= 1'b0;
            sector_num_o <= NSECT_LAST;
        end
        else
        begin
            index_o <= early;
            sector_o <= rise && !early && !phase;
            if (early)
            begin
                phase <= 1'b0;
                sector_num_o <= NSECT_LAST;
            end
            else if (rise)
            begin
                phase <= ~phase;
                if (!phase)
                    sector_num_o <= (sector_num_o == NSECT_LAST) ? '0 : sector_num_o + 1'b1;
            end
        end
    end
endmodule : sd_notch_dec
`default_nettype wire

// [core/sd_pkg.sv]
`default_nettype none
// ==========================================================
// shared constants and types of the drive sequencer
package sd_pkg;
    // clock and times as printed
    localparam longint unsigned CLK_HZ = 50_000_000;
    localparam longint unsigned SPINUP_S = 180;
    localparam longint unsigned SEEK_MS = 200;
    localparam longint unsigned HOLD_MS = 2000;
    // counter widths
    localparam int SPIN_CW = 34;
    localparam int SEEK_CW = 24;
    localparam int HOLD_CW = 27;
    localparam int NOTCH_CW = 20;
    localparam int CYL_W = 8;
    localparam int SECT_W = 5;
    // derived cycle counts (each fits its counter width, none truncated)
    localparam logic [SPIN_CW-1:0] SPINUP_CYC_DEF = SPIN_CW'(SPINUP_S * CLK_HZ);
    localparam logic [SEEK_CW-1:0] SEEK_CYC_DEF = SEEK_CW'(SEEK_MS * CLK_HZ / 1000);
    localparam logic [HOLD_CW-1:0] HOLD_CYC_DEF = HOLD_CW'(HOLD_MS * CLK_HZ / 1000);
    // sector layout
    localparam logic [SECT_W-1:0] NSECT_LAST = 5'h17;
    // register byte offsets
    localparam logic [4:0] REG_STATUS = 5'h00;
    localparam logic [4:0] REG_SEEK = 5'h04;
    localparam logic [4:0] REG_CMD = 5'h08;
    localparam logic [4:0] REG_DRIVE = 5'h0c;
    localparam logic [4:0] REG_SECTOR = 5'h10;
    // field positions
    localparam int CMD_HOME_BIT = 0;
    localparam int DRV_W = 3;
    // reset values
    localparam logic [CYL_W-1:0] CYL_RST = 8'h00;
    localparam logic [DRV_W-1:0] DRV_RST = 3'h0;
    // actuator drive modes
    typedef enum logic [1:0] {
        ACT_OFF = 2'h0,
        ACT_REVERSE = 2'h1,
        ACT_SERVO = 2'h2
    } sd_act_t;
    // sequencer states, one-hot
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_SPINUP = 7'h02,
        ST_DELAY = 7'h04,
        ST_LOAD = 7'h08,
        ST_READY = 7'h10,
        ST_SEEK = 7'h20,
        ST_STOP = 7'h40
    } sd_state_t;
    // drive pins that arrive from outside the clock domain
    typedef struct packed {
        logic cart_present;
        logic spin_req;
        logic power_off_req;
        logic dc_avail;
        logic power_safe;
        logic speed_ok;
        logic spin_stopped;
        logic fault;
        logic rem_notch;
        logic fix_notch;
    } sd_pins_t;
endpackage : sd_pkg
`default_nettype wire

// [tb/sd_ctl_model.sv]
`default_nettype none
// ==========================================
// controller side bus master, one access per request
module sd_ctl_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [4:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic wb_ack_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [4:0] wb_adr_o,
    output logic [3:0] wb_sel_o,
    output logic [31:0] wb_dat_o,
    output logic done_o,
    output logic [31:0] rdat_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // quiet bus at time zero
    initial
    begin
        {wb_cyc_o, wb_stb_o, wb_we_o, done_o} = 4'h0;
        {wb_adr_o, wb_sel_o, wb_dat_o, rdat_o} = '0;
    end
    // request held until ack, released data inverted
    always @(posedge clk_i)
    begin
        done_o <= 1'b0;
        if (rst_i)
        begin
            wb_cyc_o <= 1'b0;
            wb_stb_o <= 1'b0;
        end
        else if (wb_cyc_o && wb_ack_i)
        begin
            wb_cyc_o <= 1'b0;
            wb_stb_o <= 1'b0;
            rdat_o <= wb_dat_i;
            wb_dat_o <= ~wb_dat_o;
            done_o <= 1'b1;
        end
        else if (!wb_cyc_o && req_i && !done_o)
        begin
            wb_cyc_o <= 1'b1;
            wb_stb_o <= 1'b1;
            wb_we_o <= we_i;
            wb_adr_o <= adr_i;
            wb_dat_o <= dat_i;
            wb_sel_o <= 4'hf;
        end
    end
endmodule : sd_ctl_model
`default_nettype wire

// [tb/sd_drive_seq_props.sv]
`default_nettype none
// ==========================================
// port checker of the drive sequencer
module sd_drive_seq_props
    import sd_pkg::*;
#(
    parameter logic [SEEK_CW-1:0] SEEK_CYC = SEEK_CYC_DEF,
    parameter logic [HOLD_CW-1:0] HOLD_CYC = HOLD_CYC_DEF
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire sd_pins_t pins_i,
    input wire logic [CYL_W-1:0] present_cyl_i,
    input wire sd_act_t act_mode_o,
    input wire logic power_hold_o,
    input wire logic door_lock_o,
    input wire logic unlock_lamp_o,
    input wire logic ready_o,
    input wire logic operational_o,
    input wire logic not_on_track_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int seek_cnt;
    int hold_cnt;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================
    // run lengths of seeking and of power hold
    always_ff @(posedge clk_i)
    begin
        if (rst_i || operational_o || !ready_o)
            seek_cnt <= 0;
        else
            seek_cnt <= seek_cnt + 1;
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !power_hold_o)
            hold_cnt <= 0;
        else
            hold_cnt <= hold_cnt + 1;
    end
    // ==========================================
    // locked while active
    door_lock_a: assert property ((act_mode_o != ACT_OFF || ready_o) |-> door_lock_o)
        else $error("door open while carriage active");
    ready_zero_a: assert property ($rose(ready_o) |-> present_cyl_i == 8'h00)
        else $error("ready away from track zero");
    oper_ready_a: assert property (operational_o |-> ready_o)
        else $error("operational without ready");
    fault_drop_a: assert property (pins_i.fault [*5] |-> !ready_o)
        else $error("ready held during fault");
    nott_early_a: assert property ($rose(not_on_track_o) |-> seek_cnt >= int'(SEEK_CYC) - 3)
        else $error("off track flagged too early");
    seek_len_a: assert property (seek_cnt <= int'(SEEK_CYC) + 3)
        else $error("seek outlasts its timeout");
    stop_rev_a: assert property ($fell(pins_i.spin_req) && ready_o
        |-> ##[1:6] act_mode_o == ACT_REVERSE)
        else $error("no retract after spin withdrawn");
    unlock_cond_a: assert property ($fell(door_lock_o)
        |-> pins_i.spin_stopped && pins_i.dc_avail && !pins_i.spin_req)
        else $error("door unlocked while unsafe");
    lamp_state_a: assert property (unlock_lamp_o |-> !door_lock_o)
        else $error("unlock lamp with door locked");
    hold_lock_a: assert property (power_hold_o
        |-> door_lock_o && hold_cnt <= int'(HOLD_CYC) + 2)
        else $error("power hold too long or door open");
endmodule : sd_drive_seq_props
bind sd_drive_seq sd_drive_seq_props #(.SEEK_CYC(SEEK_CYC), .HOLD_CYC(HOLD_CYC)) i_props (
    .clk_i(clk_i), .rst_i(rst_i), .pins_i(pins_i), .present_cyl_i(present_cyl_i),
    .act_mode_o(act_mode_o), .power_hold_o(power_hold_o), .door_lock_o(door_lock_o),
    .unlock_lamp_o(unlock_lamp_o), .ready_o(ready_o), .operational_o(operational_o),
    .not_on_track_o(not_on_track_o));
`default_nettype wire

// [tb/sd_drive_seq_tb_top.sv]
`default_nettype none
// ==========================================
// top bench of the drive sequencer
module sd_drive_seq_tb_top
    import sd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [SPIN_CW-1:0] SPC = 34'h0c8;
    localparam logic [SEEK_CW-1:0] SKC = 24'h80;
    localparam logic [HOLD_CW-1:0] HLC = 27'h28;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    sd_pins_t pins = '0;
    logic [7:0] cyl = 8'h03;
    logic stall = 1'b0;
    logic req = 1'b0, we = 1'b0, done, cyc_w, stb_w, we_w, ack;
    logic [4:0] adr = 5'h00, adr_w;
    logic [3:0] sel_w;
    logic [31:0] wd = '0, rdat, wdat_w, rdat_w, rv;
    sd_act_t act_mode;
    logic [8:0] pos_err;
    logic hold, door, lamp, ready, oper, nott, r_idx, r_sec, f_idx, f_sec;
    logic [2:0] n;
    logic [7:0] tg;
    int failures = 0, checks_done = 0, cycles = 0, t0, nsec = 0, nidx = 0, nfix = 0;
    int seed = 32'hdc01;
    always #10 clk_i = ~clk_i;
    sd_drive_seq #(.SPINUP_CYC(SPC), .SEEK_CYC(SKC), .HOLD_CYC(HLC)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc_w), .wb_stb_i(stb_w), .wb_we_i(we_w),
        .wb_adr_i(adr_w), .wb_sel_i(sel_w), .wb_dat_i(wdat_w), .wb_dat_o(rdat_w),
        .wb_ack_o(ack), .pins_i(pins), .present_cyl_i(cyl), .act_mode_o(act_mode),
        .pos_err_o(pos_err), .power_hold_o(hold), .door_lock_o(door), .unlock_lamp_o(lamp),
        .ready_o(ready), .operational_o(oper), .not_on_track_o(nott), .rem_index_o(r_idx),
        .rem_sector_o(r_sec), .fix_index_o(f_idx), .fix_sector_o(f_sec));
    sd_ctl_model i_ctl (
        .clk_i(clk_i), .rst_i(rst_i), .req_i(req), .we_i(we), .adr_i(adr), .dat_i(wd),
        .wb_ack_i(ack), .wb_dat_i(rdat_w), .wb_cyc_o(cyc_w), .wb_stb_o(stb_w), .wb_we_o(we_w),
        .wb_adr_o(adr_w), .wb_sel_o(sel_w), .wb_dat_o(wdat_w), .done_o(done), .rdat_o(rdat));
    // ==========================================
    logic ph = 1'b0;
    // carriage steps every other cycle, so the registered error is fresh
    always @(posedge clk_i)
    begin
        ph <= ~ph;
        if (act_mode === ACT_SERVO && !stall && pos_err != 9'h000 && ph)
            cyl <= pos_err[8] ? cyl + 8'h01 : cyl - 8'h01;
    end
    // sector pulses counted between index pulses
    always @(posedge clk_i)
    begin
        nfix = nfix + int'(f_idx === 1'b1);
        nsec = nsec + int'(r_sec === 1'b1);
        if (r_idx === 1'b1)
        begin
            if (nidx > 0)
                chk("sectors per turn", nsec, 32'd24);
            nidx = nidx + 1;
            nsec = 0;
        end
    end
    // cycle ceiling
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        @(posedge clk_i);
        while (done !== 1'b1)
            @(posedge clk_i);
        req <= 1'b0;
        rv = rdat;
        @(posedge clk_i);
    endtask : bus
    // notch gap after notch k: short gap after 46 makes notch 47 the early index notch
    function automatic int gap(input int k);
        return (k == 46) ? 4 : ((k == 47) ? 8 : 12);
    endfunction : gap
    task automatic notches(input int revs);
        for (int r = 0; r < revs * 48; r++)
        begin
            pins.rem_notch <= 1'b1;
            pins.fix_notch <= 1'b1;
            repeat (2) @(posedge clk_i);
            pins.rem_notch <= 1'b0;
            pins.fix_notch <= 1'b0;
            repeat (gap(r % 48) - 2) @(posedge clk_i);
        end
    endtask : notches
    task automatic wait_oper();
        repeat (2) @(posedge clk_i);
        while (oper !== 1'b1)
            @(posedge clk_i);
    endtask : wait_oper
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    // ==========================================
    // main sequence
    initial
    begin
        pins.dc_avail = 1'b1;
        pins.spin_stopped = 1'b1;
        pins.power_safe = 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk("door unlocked", door, 32'h0);
        chk("unlock lamp", lamp, 32'h1);
        bus(1'b0, REG_STATUS, 32'h0);
        chk("idle state", rv[14:8], 32'h01);
        bus(1'b0, REG_DRIVE, 32'h0);
        chk("drive reset", rv[2:0], DRV_RST);
        bus(1'b1, 5'h14, 32'hffff_ffff);
        bus(1'b0, 5'h14, 32'h0);
        chk("unmapped read", rv, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            n = 3'($random(seed));
            bus(1'b1, REG_DRIVE, {29'h0, n});
            bus(1'b0, REG_DRIVE, 32'h0);
            chk("disc numbers", rv & 32'h000f_0f07, {12'h0, n, 1'b1, 4'h0, n, 1'b0, 5'h0, n});
        end
        pins.cart_present <= 1'b1;
        pins.spin_req <= 1'b1;
        pins.spin_stopped <= 1'b0;
        t0 = cycles;
        repeat (8) @(posedge clk_i);
        chk("door locked", door, 32'h1);
        chk("reverse drive", 32'(act_mode), 32'(ACT_REVERSE));
        bus(1'b1, REG_SEEK, 32'h9);
        bus(1'b0, REG_SEEK, 32'h0);
        chk("early seek", rv[7:0], CYL_RST);
        pins.speed_ok <= 1'b1;
        while (act_mode !== ACT_SERVO)
            @(posedge clk_i);
        chk("spin-up delay", 32'(cycles - t0 >= int'(SPC) && cycles - t0 <= int'(SPC) + 8), 1);
        while (ready !== 1'b1)
            @(posedge clk_i);
        chk("loaded cylinder", cyl, 32'h0);
        pins.fault <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk("ready on fault", ready, 32'h0);
        pins.fault <= 1'b0;
        wait_oper();
        for (int i = 0; i < 3; i++)
        begin
            tg = 8'($unsigned($random(seed)) % 32);
            bus(1'b1, REG_SEEK, {24'h0, tg});
            wait_oper();
            chk("seek arrival", cyl, tg);
            bus(1'b0, REG_SEEK, 32'h0);
            chk("seek target", rv[7:0], tg);
        end
        stall <= 1'b1;
        bus(1'b1, REG_SEEK, 32'h30);
        repeat (6) @(posedge clk_i);
        chk("position error", pos_err, 32'(9'({1'b0, cyl} - 9'h030)));
        wait_oper();
        chk("off track", nott, 32'h1);
        stall <= 1'b0;
        bus(1'b1, REG_CMD, 32'h1);
        wait_oper();
        chk("homed", {nott, cyl}, 32'h0);
        bus(1'b1, REG_SEEK, 32'h30);
        wait_oper();
        chk("reseek", {nott, cyl}, 32'h30);
        notches(3);
        chk("index seen", 32'(nidx >= 2 && nfix == nidx), 32'h1);
        bus(1'b0, REG_SECTOR, 32'h0);
        chk("sector numbers", rv & 32'h1f1f, 32'h1717);
        pins.spin_req <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk("stop retract", 32'(act_mode), 32'(ACT_REVERSE));
        repeat (20) @(posedge clk_i);
        chk("locked spinning", door, 32'h1);
        pins.spin_stopped <= 1'b1;
        while (door !== 1'b0)
            @(posedge clk_i);
        chk("lamp after stop", lamp, 32'h1);
        pins.spin_stopped <= 1'b0;
        pins.spin_req <= 1'b1;
        while (ready !== 1'b1)
            @(posedge clk_i);
        pins.power_off_req <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk("power hold", {hold, door}, 32'h3);
        repeat (int'(HLC) + 8) @(posedge clk_i);
        chk("hold ends", {hold, door}, 32'h1);
        tally_and_finish();
    end
endmodule : sd_drive_seq_tb_top
`default_nettype wire
